// >>> inc/iis_defs.vh
// Constants for the integer instruction execution block
`ifndef IIS_DEFS_VH
`define IIS_DEFS_VH

// Operation codes on op_code
`define IIS_NOT    5'h00
`define IIS_OR     5'h01
`define IIS_ORSR   5'h02
`define IIS_RESET  5'h03
`define IIS_FLUSH  5'h04
`define IIS_PROBE  5'h05
`define IIS_ROT    5'h06
`define IIS_ROTX   5'h07
`define IIS_RTD    5'h08
`define IIS_RTE    5'h09
`define IIS_RTR    5'h0a
`define IIS_SCC    5'h0b
`define IIS_STOP   5'h0c
`define IIS_SUB    5'h0d
`define IIS_SUBTRACT_WITH_EXTEND   5'h0e
`define IIS_TST    5'h0f
`define IIS_TAS    5'h10
`define IIS_TRAP   5'h11
`define IIS_UNLINK_FRAME   5'h12
`define IIS_BCD_COMPRESS   5'h13
`define IIS_BCD_EXPAND   5'h14
`define IIS_LMOVE  5'h15

// Operand sizes on op_size
`define IIS_SZ_B   2'h0
`define IIS_SZ_W   2'h1
`define IIS_SZ_L   2'h2

// APB register byte offsets
`define IIS_A_SR     8'h00
`define IIS_A_USP    8'h04
`define IIS_A_SSP    8'h08
`define IIS_A_TSR    8'h0c
`define IIS_A_STAT   8'h10
`define IIS_A_RESUME 8'h14

// Status register fields and reset values
`define IIS_SR_T     15
`define IIS_SR_S     13
`define IIS_SR_RST   16'h2700
`define IIS_SP_RST   32'h00000000
`define IIS_CCR_W    5

// Stack steps and frame layout
`define IIS_STK_W      32'h00000002
`define IIS_STK_L      32'h00000004
`define IIS_FMT_LONG   4'h2
`define IIS_FMT_EXTRA  32'h00000004
`define IIS_LINE_BYTES 32'h00000010
`define IIS_TAS_BIT    32'h00000080

// Cycles that the external reset line stays asserted
`define IIS_RST_OUT_CYC 10'd512

`endif

// >>> src/iis_exec.v
// Execution unit for logic, subtract, rotate, BCD, stack and privileged operations
//
// Overview of operation
// RL1: Complement replaces the destination with its one's complement.
// RL2: OR writes source OR destination into the destination.
// RL3: Status register OR only in supervisor; user traps, register kept.
// RL4: Reset in supervisor asserts reset output line; user traps.
// RL5: Flush invalidates translation entries per variant; user traps.
// RL6: Probe writes translation status, loads an entry; user traps.
// RL7: Plain rotate left or right by register or immediate count.
// RL8: Rotate through extend rotates destination with extend flag by the count.
// RL9: Return-and-deallocate pops pc, then adds 4 plus displacement.
// RL10: Return from exception pops status, pc, frame format; user traps.
// RL11: Return-and-restore-codes pops condition codes, adds 2, pops pc, adds 4.
// RL12: Set-on-condition writes all ones when true, otherwise all zeros.
// RL13: Stop loads immediate into status register and halts; user traps.
// RL14: Subtract writes destination minus source; address form targets address register.
// RL15: Subtract with extend writes destination minus source minus extend.
// RL16: Test sets condition codes from destination without altering it.
// RL17: Test-and-set sets codes from destination, then sets its bit 7.
// RL18: Trap pushes format/offset, pc, status on system stack, loads vector.
// RL19: Unlink copies address register to stack pointer, pops it, adds 4.
// RL20: Compress converts unpacked BCD plus adjustment into packed BCD.
// RL21: Expand converts packed BCD plus adjustment into unpacked BCD.
// RL22: Same-register line move increments once, copies the line onto itself.
// RL23: Privileged op in user state requests a trap, suppresses all effects.
`timescale 1ns/1ns
`include "iis_defs.vh"

module iis_exec (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Decoded instruction
	input  wire        op_valid,
	output wire        op_ready,
	input  wire [4:0]  op_code,
	input  wire [1:0]  op_var,
	input  wire [1:0]  op_size,
	input  wire [31:0] op_src,
	input  wire [31:0] op_dst,
	input  wire [31:0] op_imm,
	input  wire [31:0] op_pc,
	input  wire        op_cond,
	input  wire        op_same_reg,
	// Completion and results
	output wire        op_done,
	output wire        res_valid,
	output wire [31:0] res_data,
	output wire [31:0] res_aux,
	output wire        pc_load,
	output wire [31:0] pc_value,
	output wire        priv_req,
	// Stack memory
	output wire        mem_req,
	output wire        mem_we,
	output wire        mem_wide,
	output wire [31:0] mem_addr,
	output wire [31:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [31:0] mem_rdata,
	// Translation cache
	output wire        tc_flush,
	output wire [1:0]  tc_flush_mode,
	output wire [31:0] tc_addr,
	output wire        tc_probe,
	output wire        tc_probe_wr,
	input  wire        tc_probe_done,
	input  wire [31:0] tc_probe_status,
	// Line move
	output wire        line_go,
	output wire [31:0] line_src,
	output wire [31:0] line_dst,
	// Status
	output wire [15:0] status_register,
	output wire        reset_out_line,
	output wire        halted
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SET  = 3'h1;
	localparam [2:0] ST_ACC  = 3'h2;
	localparam [2:0] ST_FIN  = 3'h3;
	localparam [2:0] ST_PRB  = 3'h4;

	reg [2:0]  st_q;
	reg [1:0]  stp_q;
	reg [4:0]  op_q;
	reg [31:0] imm_q;
	reg [31:0] src_q;
	reg [31:0] pc_q;
	reg        sel_q;
	reg [15:0] sr_q;
	reg [15:0] srt_q;
	reg [31:0] usp_q;
	reg [31:0] ssp_q;
	reg [31:0] tsr_q;
	reg        halted_q;
	reg [9:0]  rst_cnt_q;
	reg [31:0] prdata_q;
	reg        done_q;
	reg        res_valid_q;
	reg [31:0] res_data_q;
	reg [31:0] res_aux_q;
	reg        pc_load_q;
	reg [31:0] pc_value_q;
	reg        priv_q;
	reg        mem_we_q;
	reg        mem_wide_q;
	reg [31:0] mem_addr_q;
	reg [31:0] mem_wdata_q;
	reg        tc_flush_q;
	reg [1:0]  tc_mode_q;
	reg [31:0] tc_addr_q;
	reg        tc_probe_q;
	reg        tc_wr_q;
	reg        line_go_q;
	reg [31:0] line_src_q;
	reg [31:0] line_dst_q;

	function [31:0] szm;
		input [1:0] sz;
		begin
			szm = (sz == `IIS_SZ_B) ? 32'h000000ff :
				(sz == `IIS_SZ_W) ? 32'h0000ffff : 32'hffffffff;
		end
	endfunction

	function sgn;
		input [31:0] v;
		input [1:0]  sz;
		begin
			sgn = (sz == `IIS_SZ_B) ? v[7] : (sz == `IIS_SZ_W) ? v[15] : v[31];
		end
	endfunction

	// Returns {extend, carry, value}; loop bound covers a count of 63
	function [33:0] rotf;
		input [31:0] v;
		input [5:0]  n;
		input        l;
		input        xe;
		input        xi;
		input [1:0]  sz;
		reg [31:0] r;
		reg [31:0] mk;
		reg        o;
		reg        x;
		reg        c;
		integer    i;
		integer    m;
		begin
			mk = szm(sz);
			m = (sz == `IIS_SZ_B) ? 7 : (sz == `IIS_SZ_W) ? 15 : 31;
			r = v & mk;
			x = xi;
			c = xe & xi;
			o = 1'b0;
			for (i = 0; i < 63; i = i + 1) begin
				if (i < n) begin
					if (l) begin
						o = r[m];
						r = ((r << 1) | {31'h0, (xe ? x : o)}) & mk;
					end else begin
						o = r[0];
						r = r >> 1;
						r[m] = xe ? x : o;
					end
					if (xe)
						x = o;
					c = o;
				end
			end
			rotf = {x, c, r};
		end
	endfunction

	wire        s_bit  = sr_q[`IIS_SR_S];
	wire        xflag  = sr_q[4];
	wire [31:0] sp_cur = sel_q ? ssp_q : usp_q;
	wire        take   = op_valid & op_ready;
	wire        priv   = (op_code == `IIS_ORSR && !op_var[0]) || op_code == `IIS_RESET ||
		op_code == `IIS_FLUSH || op_code == `IIS_PROBE || op_code == `IIS_RTE ||
		op_code == `IIS_STOP;

	// Single-cycle datapath
	reg [31:0] al_r;
	reg [4:0]  al_cc;
	reg        al_w;
	reg        al_f;
	reg [31:0] mk;
	reg [31:0] s;
	reg [31:0] d;
	reg [33:0] rt;
	reg [15:0] t;
	reg        rm;
	reg        sm;
	reg        dm;

	always @* begin
		mk = szm(op_size);
		s = op_src & mk;
		d = op_dst & mk;
		al_r = d;
		al_w = 1'b1;
		al_f = 1'b1;
		rt = 34'h0;
		t = 16'h0;
		case (op_code)
			`IIS_NOT: al_r = ~d & mk; // RL1
			`IIS_OR:  al_r = s | d; // RL2
			`IIS_TST: al_w = 1'b0; // RL16
			`IIS_TAS: al_r = d | `IIS_TAS_BIT; // RL17
			`IIS_SCC: begin
				al_r = op_cond ? mk : 32'h0; // RL12
				al_f = 1'b0;
			end
			`IIS_SUB: begin
				if (op_var[0]) begin
					al_r = op_dst - op_src; // RL14
					al_f = 1'b0;
				end else
					al_r = (d - s) & mk; // RL14
			end
			`IIS_SUBTRACT_WITH_EXTEND: al_r = (d - s - {31'h0, xflag}) & mk; // RL15
			`IIS_ROT: begin
				rt = rotf(op_dst, op_src[5:0], op_var[0], 1'b0, xflag, op_size); // RL7
				al_r = rt[31:0];
			end
			`IIS_ROTX: begin
				rt = rotf(op_dst, op_src[5:0], op_var[0], 1'b1, xflag, op_size); // RL8
				al_r = rt[31:0];
			end
			`IIS_BCD_COMPRESS: begin
				t = op_src[15:0] + op_imm[15:0]; // RL20
				al_r = {24'h0, t[11:8], t[3:0]};
				al_f = 1'b0;
			end
			`IIS_BCD_EXPAND: begin
				t = {4'h0, op_src[7:4], 4'h0, op_src[3:0]} + op_imm[15:0]; // RL21
				al_r = {16'h0, t};
				al_f = 1'b0;
			end
			default: begin
				al_w = 1'b0;
				al_f = 1'b0;
			end
		endcase
		rm = sgn(al_r, op_size);
		sm = sgn(s, op_size);
		dm = sgn(d, op_size);
		// Logic ops keep extend, clear overflow and carry
		al_cc = {xflag, rm, (al_r == 32'h0), 2'b00};
		if (op_code == `IIS_TST || op_code == `IIS_TAS)
			al_cc = {xflag, dm, (d == 32'h0), 2'b00};
		if (op_code == `IIS_SUB || op_code == `IIS_SUBTRACT_WITH_EXTEND) begin
			al_cc[0] = (sm & ~dm) | (rm & ~dm) | (sm & rm);
			al_cc[4] = al_cc[0];
			al_cc[1] = (~sm & dm & ~rm) | (sm & ~dm & rm);
		end
		if (op_code == `IIS_SUBTRACT_WITH_EXTEND)
			al_cc[2] = (al_r == 32'h0) & sr_q[2];
		if (op_code == `IIS_ROT)
			al_cc[0] = rt[32];
		if (op_code == `IIS_ROTX) begin
			al_cc[0] = rt[32];
			al_cc[4] = rt[33];
		end
	end

	// Stack access of the current step
	reg [31:0] acc_addr;
	reg [31:0] acc_sp;
	reg [31:0] acc_wdata;
	reg        acc_wide;
	reg        acc_we;
	reg        acc_last;

	always @* begin
		acc_wide = (stp_q == 2'h1);
		acc_we = 1'b0;
		acc_last = (stp_q == 2'h1);
		acc_wdata = 32'h0;
		if (op_q == `IIS_RTD || op_q == `IIS_UNLINK_FRAME) begin
			acc_wide = 1'b1;
			acc_last = (stp_q == 2'h0);
		end
		if (op_q == `IIS_RTE || op_q == `IIS_TRAP)
			acc_last = (stp_q == 2'h2);
		acc_addr = sp_cur;
		acc_sp = sp_cur + (acc_wide ? `IIS_STK_L : `IIS_STK_W);
		if (op_q == `IIS_TRAP) begin
			acc_we = 1'b1;
			acc_addr = sp_cur - (acc_wide ? `IIS_STK_L : `IIS_STK_W); // RL18
			acc_sp = acc_addr;
			acc_wdata = (stp_q == 2'h0) ? {20'h0, imm_q[11:0]} :
				(stp_q == 2'h1) ? pc_q : {16'h0, sr_q};
		end
		if (op_q == `IIS_RTD)
			acc_sp = sp_cur + `IIS_STK_L + imm_q; // RL9
		if (op_q == `IIS_RTE && stp_q == 2'h2)
			acc_sp = sp_cur + `IIS_STK_W +
				((mem_rdata[15:12] == `IIS_FMT_LONG) ? `IIS_FMT_EXTRA : 32'h0); // RL10
	end

	// APB decode
	wire apb_hit = (paddr == `IIS_A_SR) || (paddr == `IIS_A_USP) ||
		(paddr == `IIS_A_SSP) || (paddr == `IIS_A_TSR) ||
		(paddr == `IIS_A_STAT) || (paddr == `IIS_A_RESUME);
	wire apb_wr = psel & penable & pwrite & apb_hit;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_IDLE;
			stp_q <= 2'h0;
			op_q <= 5'h0;
			imm_q <= 32'h0;
			src_q <= 32'h0;
			pc_q <= 32'h0;
			sel_q <= 1'b0;
			sr_q <= `IIS_SR_RST;
			srt_q <= 16'h0;
			usp_q <= `IIS_SP_RST;
			ssp_q <= `IIS_SP_RST;
			tsr_q <= 32'h0;
			halted_q <= 1'b0;
			rst_cnt_q <= 10'd0;
			prdata_q <= 32'h0;
			done_q <= 1'b0;
			res_valid_q <= 1'b0;
			res_data_q <= 32'h0;
			res_aux_q <= 32'h0;
			pc_load_q <= 1'b0;
			pc_value_q <= 32'h0;
			priv_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_wide_q <= 1'b0;
			mem_addr_q <= 32'h0;
			mem_wdata_q <= 32'h0;
			tc_flush_q <= 1'b0;
			tc_mode_q <= 2'h0;
			tc_addr_q <= 32'h0;
			tc_probe_q <= 1'b0;
			tc_wr_q <= 1'b0;
			line_go_q <= 1'b0;
			line_src_q <= 32'h0;
			line_dst_q <= 32'h0;
		end else begin
			done_q <= 1'b0;
			res_valid_q <= 1'b0;
			pc_load_q <= 1'b0;
			priv_q <= 1'b0;
			tc_flush_q <= 1'b0;
			tc_probe_q <= 1'b0;
			line_go_q <= 1'b0;
			if (rst_cnt_q != 10'd0)
				rst_cnt_q <= rst_cnt_q - 10'd1;
			// Read data captured in the setup phase
			if (psel && !penable) begin
				case (paddr)
					`IIS_A_SR:   prdata_q <= {16'h0, sr_q};
					`IIS_A_USP:  prdata_q <= usp_q;
					`IIS_A_SSP:  prdata_q <= ssp_q;
					`IIS_A_TSR:  prdata_q <= tsr_q;
					`IIS_A_STAT: prdata_q <= {29'h0, (rst_cnt_q != 10'd0), halted_q,
						(st_q != ST_IDLE)};
					default:     prdata_q <= 32'h0;
				endcase
			end
			// Software writes; hardware updates below take precedence
			if (apb_wr) begin
				case (paddr)
					`IIS_A_SR:     sr_q <= pwdata[15:0];
					`IIS_A_USP:    usp_q <= pwdata;
					`IIS_A_SSP:    ssp_q <= pwdata;
					`IIS_A_RESUME: if (pwdata[0]) halted_q <= 1'b0;
					default:       ;
				endcase
			end
			case (st_q)
				ST_IDLE: if (take) begin
					op_q <= op_code;
					imm_q <= op_imm;
					src_q <= op_src;
					pc_q <= op_pc;
					sel_q <= s_bit;
					stp_q <= 2'h0;
					if (priv && !s_bit) begin
						priv_q <= 1'b1; // RL23 RL3 RL4 RL5 RL6 RL10 RL13
						done_q <= 1'b1;
					end else begin
						case (op_code)
							`IIS_ORSR: begin
								if (op_var[0])
									sr_q[4:0] <= sr_q[4:0] | op_imm[4:0];
								else
									sr_q <= sr_q | op_imm[15:0]; // RL3
								done_q <= 1'b1;
							end
							`IIS_RESET: begin
								rst_cnt_q <= `IIS_RST_OUT_CYC; // RL4
								done_q <= 1'b1;
							end
							`IIS_FLUSH: begin
								tc_flush_q <= 1'b1; // RL5
								tc_mode_q <= op_var;
								tc_addr_q <= op_src;
								done_q <= 1'b1;
							end
							`IIS_PROBE: begin
								tc_probe_q <= 1'b1; // RL6
								tc_wr_q <= op_var[0];
								tc_addr_q <= op_src;
								st_q <= ST_PRB;
							end
							`IIS_STOP: begin
								sr_q <= op_imm[15:0]; // RL13
								halted_q <= 1'b1;
								done_q <= 1'b1;
							end
							`IIS_RTD, `IIS_RTE, `IIS_RTR: st_q <= ST_SET;
							`IIS_TRAP: begin
								sel_q <= 1'b1; // RL18
								st_q <= ST_SET;
							end
							`IIS_UNLINK_FRAME: begin
								if (s_bit)
									ssp_q <= op_src; // RL19
								else
									usp_q <= op_src; // RL19
								st_q <= ST_SET;
							end
							`IIS_LMOVE: begin
								line_go_q <= 1'b1;
								line_src_q <= op_src;
								line_dst_q <= op_same_reg ? op_src : op_dst; // RL22
								res_data_q <= op_src + `IIS_LINE_BYTES;
								res_aux_q <= (op_same_reg ? op_src : op_dst) +
									`IIS_LINE_BYTES; // RL22
								res_valid_q <= 1'b1;
								done_q <= 1'b1;
							end
							default: begin
								res_data_q <= al_r;
								res_aux_q <= 32'h0;
								res_valid_q <= al_w;
								if (al_f)
									sr_q[4:0] <= al_cc; // RL16 RL17
								done_q <= 1'b1;
							end
						endcase
					end
				end
				ST_SET: begin
					mem_we_q <= acc_we;
					mem_wide_q <= acc_wide;
					mem_addr_q <= acc_addr;
					mem_wdata_q <= acc_wdata;
					st_q <= ST_ACC;
				end
				ST_ACC: if (mem_ack) begin
					if (sel_q)
						ssp_q <= acc_sp;
					else
						usp_q <= acc_sp;
					if (op_q == `IIS_RTR && stp_q == 2'h0)
						sr_q[4:0] <= mem_rdata[4:0]; // RL11
					if (op_q == `IIS_RTE && stp_q == 2'h0)
						srt_q <= mem_rdata[15:0]; // RL10
					if (op_q == `IIS_UNLINK_FRAME)
						res_data_q <= mem_rdata; // RL19
					if (op_q != `IIS_TRAP && acc_wide)
						pc_value_q <= mem_rdata; // RL9 RL10 RL11
					if (acc_last)
						st_q <= ST_FIN;
					else begin
						stp_q <= stp_q + 2'h1;
						st_q <= ST_SET;
					end
				end
				ST_FIN: begin
					if (op_q == `IIS_UNLINK_FRAME) begin
						res_aux_q <= 32'h0;
						res_valid_q <= 1'b1;
					end else
						pc_load_q <= 1'b1;
					if (op_q == `IIS_RTE)
						sr_q <= srt_q; // RL10
					if (op_q == `IIS_TRAP) begin
						pc_value_q <= src_q; // RL18
						sr_q[`IIS_SR_S] <= 1'b1;
						sr_q[`IIS_SR_T] <= 1'b0;
					end
					done_q <= 1'b1;
					st_q <= ST_IDLE;
				end
				ST_PRB: if (tc_probe_done) begin
					tsr_q <= tc_probe_status; // RL6
					done_q <= 1'b1;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;
	assign op_ready = (st_q == ST_IDLE) & ~halted_q & (rst_cnt_q == 10'd0);
	assign op_done = done_q;
	assign res_valid = res_valid_q;
	assign res_data = res_data_q;
	assign res_aux = res_aux_q;
	assign pc_load = pc_load_q;
	assign pc_value = pc_value_q;
	assign priv_req = priv_q;
	assign mem_req = (st_q == ST_ACC);
	assign mem_we = mem_we_q;
	assign mem_wide = mem_wide_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign tc_flush = tc_flush_q;
	assign tc_flush_mode = tc_mode_q;
	assign tc_addr = tc_addr_q;
	assign tc_probe = tc_probe_q;
	assign tc_probe_wr = tc_wr_q;
	assign line_go = line_go_q;
	assign line_src = line_src_q;
	assign line_dst = line_dst_q;
	assign status_register = sr_q;
	assign reset_out_line = (rst_cnt_q != 10'd0); // RL4
	assign halted = halted_q;

endmodule // iis_exec

// >>> tb/iis_exec_monitor.sv
// Assertion checker for the instruction execution block
`timescale 1ns/1ns
`include "iis_defs.vh"
module iis_exec_monitor (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// APB
	input wire        psel,
	input wire        penable,
	input wire [7:0]  paddr,
	input wire        pready,
	input wire        pslverr,
	// Instruction
	input wire        op_valid,
	input wire        op_ready,
	input wire [4:0]  op_code,
	input wire [1:0]  op_var,
	input wire [1:0]  op_size,
	input wire [31:0] op_src,
	input wire [31:0] op_dst,
	input wire        op_cond,
	// Results and status
	input wire        op_done,
	input wire        res_valid,
	input wire [31:0] res_data,
	input wire        priv_req,
	input wire        mem_req,
	input wire        mem_ack,
	input wire [31:0] mem_addr,
	input wire [15:0] status_register,
	input wire        reset_out_line,
	input wire        halted
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire tk  = op_valid && op_ready;
	wire lng = op_size == `IIS_SZ_L;
	wire sup = status_register[`IIS_SR_S];
	wire prv = (op_code == `IIS_ORSR && !op_var[0]) || op_code == `IIS_RESET ||
		op_code == `IIS_FLUSH || op_code == `IIS_PROBE || op_code == `IIS_RTE ||
		op_code == `IIS_STOP;
	not_result_a: assert property (tk && op_code == `IIS_NOT && lng |=>
		res_valid && res_data == ~$past(op_dst)) else $error("complement wrong");
	or_result_a: assert property (tk && op_code == `IIS_OR && lng |=>
		res_data == ($past(op_src) | $past(op_dst))) else $error("or wrong");
	sub_result_a: assert property (tk && op_code == `IIS_SUB && lng && !op_var[0] |=>
		res_data == $past(op_dst) - $past(op_src)) else $error("subtract wrong");
	scc_fill_a: assert property (tk && op_code == `IIS_SCC && lng |=>
		res_data == ($past(op_cond) ? 32'hffffffff : 32'h0)) else $error("set wrong");
	tas_bit_a: assert property (tk && op_code == `IIS_TAS && op_size == `IIS_SZ_B |=>
		res_data[7:0] == ($past(op_dst[7:0]) | 8'h80)) else $error("tas wrong");
	tst_keep_a: assert property (tk && op_code == `IIS_TST |=> op_done && !res_valid)
		else $error("test wrote a result");
	priv_trap_a: assert property (tk && prv && !sup |=> priv_req && op_done && !res_valid)
		else $error("no privilege trap");
	sr_kept_a: assert property (tk && prv && !sup |=> $stable(status_register))
		else $error("status changed in user state");
	reset_line_a: assert property (tk && op_code == `IIS_RESET && sup |=>
		##[0:1] reset_out_line) else $error("reset line not asserted");
	stop_halt_a: assert property (tk && op_code == `IIS_STOP && sup |=> ##[0:1] halted)
		else $error("stop did not halt");
	halt_block_a: assert property (halted |-> !op_ready)
		else $error("ready while halted");
	apb_err_a: assert property (psel && penable && paddr > 8'h14 |-> pready && pslverr)
		else $error("unmapped access without error");
	mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped");
	priv_c: cover property (priv_req);
	rst_c: cover property ($rose(reset_out_line));
	halt_c: cover property ($rose(halted));
	mem_c: cover property (mem_req && mem_ack);
endmodule // iis_exec_monitor

bind iis_exec iis_exec_monitor mon_u (.*);

// >>> tb/iis_stack_mem.sv
// Stack memory and translation cache responder
`timescale 1ns/1ns
module iis_stack_mem (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	input  wire        slow,
	// Stack memory
	input  wire        mem_req,
	input  wire        mem_we,
	input  wire        mem_wide,
	input  wire [31:0] mem_addr,
	input  wire [31:0] mem_wdata,
	output reg         mem_ack,
	output reg  [31:0] mem_rdata,
	// Translation cache
	input  wire        tc_probe,
	output reg         tc_probe_done,
	output wire [31:0] tc_probe_status
);
	parameter [31:0] PROBE_STAT = 32'h000000a5;
	reg  [15:0] m [0:63];
	reg  [1:0]  wait_q;
	wire [5:0]  ix = mem_addr[6:1];
	// Status is only meaningful with the done pulse
	assign tc_probe_status = tc_probe_done ? PROBE_STAT : ~PROBE_STAT;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_q <= 2'h0;
			tc_probe_done <= 1'b0;
			mem_rdata <= 32'h0;
		end else begin
			tc_probe_done <= tc_probe;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && mem_ack) begin
				wait_q <= 2'h0;
				if (mem_we && mem_wide) begin
					m[ix] <= mem_wdata[31:16];
					m[ix + 6'h1] <= mem_wdata[15:0];
				end else if (mem_we)
					m[ix] <= mem_wdata[15:0];
			end else if (mem_req && wait_q == (slow ? 2'h3 : 2'h0)) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_wide ? {m[ix], m[ix + 6'h1]} : {16'h0, m[ix]};
			end else if (mem_req)
				wait_q <= wait_q + 2'h1;
		end
	end
endmodule // iis_stack_mem

// >>> tb/testbench.sv
// Self-checking bench for the instruction execution block
`timescale 1ns/1ns
`include "iis_defs.vh"
module testbench;
	reg         pclk, presetn, psel, penable, pwrite, op_valid, op_cond, op_same_reg, slow;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata, op_src, op_dst, op_imm, op_pc, rd, pcs;
	reg  [4:0]  op_code;
	reg  [1:0]  op_var, op_size, flm;
	reg         err, prv, rv, fls, prw;
	wire [31:0] prdata, res_data, res_aux, pc_value, mem_addr, mem_wdata, mem_rdata, tc_addr;
	wire [31:0] tc_probe_status, line_src, line_dst;
	wire [15:0] status_register;
	wire [1:0]  tc_flush_mode;
	wire        pready, pslverr, op_ready, op_done, res_valid, pc_load, priv_req, mem_req;
	wire        mem_we, mem_wide, mem_ack, tc_flush, tc_probe, tc_probe_wr, tc_probe_done;
	wire        line_go, reset_out_line, halted;
	integer     mismatches, tests_run, i, rcnt;
	localparam [29:0] PRIV = {`IIS_ORSR, `IIS_RESET, `IIS_FLUSH, `IIS_PROBE, `IIS_RTE,
		`IIS_STOP};

	iis_exec dut_u (.*);
	iis_stack_mem mem_u (.*);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Sticky capture of pulses; rcnt counts the cycles that reset_out_line is high
	always @(negedge pclk) begin
		if (pc_load === 1'b1) pcs <= pc_value;
		if (tc_flush === 1'b1) {fls, flm} <= {1'b1, tc_flush_mode};
		if (tc_probe === 1'b1) prw <= tc_probe_wr;
		if (reset_out_line === 1'b1) rcnt <= rcnt + 1;
	end

	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task issue(input [4:0] c, input [1:0] v, input [1:0] s, input [31:0] sr, input [31:0] ds,
		input [31:0] im);
		begin
			@(posedge pclk);
			op_valid <= 1'b1;
			op_code <= c;
			op_var <= v;
			op_size <= s;
			op_src <= sr;
			op_dst <= ds;
			op_imm <= im;
			@(posedge pclk);
			while (op_ready !== 1'b1) @(posedge pclk);
			op_valid <= 1'b0;
			@(posedge pclk);
			while (op_done !== 1'b1) @(posedge pclk);
			prv = priv_req;
			rv = res_valid;
		end
	endtask

	task t_regs;
		begin
			apb(0, `IIS_A_SR, 0);
			chk(rd, 32'h2700);
			apb(0, `IIS_A_SSP, 0);
			chk(rd, 32'h0);
			apb(0, `IIS_A_RESUME, 0);
			chk(rd, 32'h0);
			apb(0, 8'h20, 0);
			chk({31'h0, err}, 1);
		end
	endtask
	task t_alu;
		begin
			issue(`IIS_NOT, 0, `IIS_SZ_L, 0, 32'h0f0f1234, 0); chk(res_data, 32'hf0f0edcb);
			issue(`IIS_OR, 0, `IIS_SZ_L, 32'h00ff0001, 32'h12000010, 0);
			chk(res_data, 32'h12ff0011);
			issue(`IIS_SUB, 0, `IIS_SZ_L, 5, 3, 0); chk(res_data, 32'hfffffffe);
			issue(`IIS_SUB, 1, `IIS_SZ_L, 32'h10, 32'h1000, 0); chk(res_data, 32'hff0);
			op_cond <= 1'b1;
			issue(`IIS_SCC, 0, `IIS_SZ_L, 0, 0, 0); chk(res_data, 32'hffffffff);
			op_cond <= 1'b0;
			issue(`IIS_SCC, 0, `IIS_SZ_L, 0, 32'h5, 0); chk(res_data, 32'h0);
			issue(`IIS_TST, 0, `IIS_SZ_L, 0, 32'h80000000, 0); chk({31'h0, rv}, 0);
			chk({31'h0, status_register[3]}, 1);
			issue(`IIS_TAS, 0, `IIS_SZ_B, 0, 0, 0); chk(res_data & 32'hff, 32'h80);
			chk({31'h0, status_register[2]}, 1);
			issue(`IIS_ROT, 1, `IIS_SZ_L, 4, 32'h12345678, 0); chk(res_data, 32'h23456781);
			issue(`IIS_ROT, 0, `IIS_SZ_L, 8, 32'h12345678, 0); chk(res_data, 32'h78123456);
			apb(1, `IIS_A_SR, 32'h2710);
			issue(`IIS_ROTX, 1, `IIS_SZ_L, 1, 32'h80000001, 0); chk(res_data, 32'h3);
			chk({31'h0, status_register[4]}, 1);
			issue(`IIS_SUBTRACT_WITH_EXTEND, 0, `IIS_SZ_L, 3, 32'h10, 0); chk(res_data, 32'hc);
			issue(`IIS_BCD_COMPRESS, 0, `IIS_SZ_B, 32'h304, 0, 32'h101); chk(res_data & 32'hff, 32'h45);
			issue(`IIS_BCD_EXPAND, 0, `IIS_SZ_W, 32'h34, 0, 32'h3030);
			chk(res_data & 32'hffff, 32'h3334);
			op_same_reg <= 1'b1;
			issue(`IIS_LMOVE, 0, `IIS_SZ_L, 32'h100, 32'h100, 0); chk(res_aux, 32'h110);
			chk(line_dst, 32'h100);
			chk(line_src, 32'h100);
			op_same_reg <= 1'b0;
		end
	endtask
	task t_stack;
		begin
			apb(1, `IIS_A_SSP, 32'h20);
			mem_u.m[16] = 16'h0;
			mem_u.m[17] = 16'h1000;
			issue(`IIS_RTD, 0, `IIS_SZ_L, 0, 0, 32'h8); chk(pcs, 32'h1000);
			apb(0, `IIS_A_SSP, 0); chk(rd, 32'h2c);
			apb(1, `IIS_A_SSP, 32'h20);
			mem_u.m[16] = 16'h1f;
			mem_u.m[17] = 16'h0;
			mem_u.m[18] = 16'h2000;
			slow <= 1'b1;
			issue(`IIS_RTR, 0, `IIS_SZ_W, 0, 0, 0); chk(pcs, 32'h2000);
			chk({27'h0, status_register[4:0]}, 32'h1f);
			apb(0, `IIS_A_SSP, 0); chk(rd, 32'h26);
			mem_u.m[24] = 16'habcd;
			mem_u.m[25] = 16'h0123;
			issue(`IIS_UNLINK_FRAME, 0, `IIS_SZ_L, 32'h30, 0, 0); chk(res_data, 32'habcd0123);
			apb(0, `IIS_A_SSP, 0); chk(rd, 32'h34);
			apb(1, `IIS_A_SSP, 32'h40);
			apb(1, `IIS_A_SR, 32'h2700);
			op_pc <= 32'h1234;
			issue(`IIS_TRAP, 0, `IIS_SZ_L, 32'h3000, 0, 32'h80); chk(pcs, 32'h3000);
			apb(0, `IIS_A_SSP, 0); chk(rd, 32'h38);
			chk({20'h0, mem_u.m[31][11:0]}, 32'h80);
			chk({mem_u.m[29], mem_u.m[30]}, 32'h1234);
			chk({16'h0, mem_u.m[28]}, 32'h2700);
			apb(1, `IIS_A_SR, 32'h2704);
			issue(`IIS_RTE, 0, `IIS_SZ_W, 0, 0, 0); chk(pcs, 32'h1234);
			chk({16'h0, status_register}, 32'h2700);
			apb(0, `IIS_A_SSP, 0); chk(rd, 32'h40);
		end
	endtask
	task t_priv;
		begin
			apb(1, `IIS_A_SR, 32'h0);
			for (i = 5; i >= 0; i = i - 1) begin
				issue(PRIV[i*5 +: 5], 0, `IIS_SZ_W, 0, 0, 32'h2700); chk({31'h0, prv}, 1);
				chk({16'h0, status_register}, 32'h0);
			end
			chk({31'h0, fls}, 0);
			chk({30'h0, reset_out_line, halted}, 0);
			apb(1, `IIS_A_SR, 32'h2700);
		end
	endtask
	task t_super;
		begin
			issue(`IIS_ORSR, 0, `IIS_SZ_W, 0, 0, 32'h11); chk({31'h0, prv}, 0);
			apb(0, `IIS_A_SR, 0); chk(rd, 32'h2711);
			issue(`IIS_ORSR, 1, `IIS_SZ_W, 0, 0, 32'h804); chk({16'h0, status_register}, 32'h2715);
			for (i = 0; i < 4; i = i + 1) begin
				fls = 1'b0;
				issue(`IIS_FLUSH, i, `IIS_SZ_L, 32'h4000, 0, 0); chk({31'h0, fls}, 1);
				chk({30'h0, flm}, i);
				chk(tc_addr, 32'h4000);
			end
			for (i = 0; i < 2; i = i + 1) begin
				issue(`IIS_PROBE, i, `IIS_SZ_L, 32'h4000, 0, 0); chk({31'h0, prw}, i);
				apb(0, `IIS_A_TSR, 0); chk(rd, 32'ha5);
			end
			rcnt = 0;
			issue(`IIS_RESET, 0, `IIS_SZ_L, 0, 0, 0);
			while (reset_out_line !== 1'b0) @(posedge pclk);
			chk(rcnt, 512);
			issue(`IIS_STOP, 0, `IIS_SZ_W, 0, 0, 32'h2704);
			@(posedge pclk);
			chk({31'h0, halted}, 1);
			chk({16'h0, status_register}, 32'h2704);
			apb(1, `IIS_A_RESUME, 32'h1);
			@(posedge pclk);
			chk({31'h0, halted}, 0);
		end
	endtask
	task end_sim;
		begin
			$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, op_valid, op_cond, op_same_reg, slow} = 8'h0;
		{paddr, pwdata, op_src, op_dst, op_imm, op_pc, op_code, op_var, op_size} = 0;
		{fls, prw, flm, pcs} = 0;
		mismatches = 0;
		tests_run = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_alu;
		t_stack;
		t_priv;
		t_super;
		end_sim;
	end
	initial begin
		#80000;
		mismatches = mismatches + 1;
		end_sim;
	end
endmodule // testbench
